/* File: hdl/fps_eraser.sv */
`timescale 1ns/10ps
module fps_eraser
   import fps_pkg::*;
(
   input wire logic clock, // system clock
   input wire logic rst_n, // async reset, active low
   input wire logic ce, // clock enable
   input wire logic start, // one-cycle start of protection erase
   input wire logic array_fail, // array macro reports a failed erase
   output logic busy, // erase in progress
   output logic failed, // erase failed, locked until reset
   output logic array_phase, // array cells being erased
   output logic prot_phase, // protection bits being erased
   output logic done, // one-cycle pulse, erase finished well
   output logic prot_clr // one-cycle pulse, clear protection bits
);
   typedef struct packed {
      fps_ers_t phase;
      logic [CNT_W-1:0] cnt;
      logic done;
      logic prot_clr;
   } fps_ers_state_t;

   fps_ers_state_t s_q;
   fps_ers_state_t s_d;

   always_comb
   begin
      s_d = s_q;
      s_d.done = 1'b0;
      s_d.prot_clr = 1'b0;
      case (s_q.phase)
         ERS_IDLE:
         begin
            if (start)
            begin
               s_d.phase = ERS_ARRAY;
               s_d.cnt = CNT_W'(ARRAY_ERASE_CYC - 1);
            end
         end
         ERS_ARRAY:
         begin
            if (array_fail)
               s_d.phase = ERS_FAIL;
            else if (s_q.cnt == '0)
            begin
               // protection bits only go after the array is blank
               s_d.phase = ERS_PROT;
               s_d.cnt = CNT_W'(PROT_ERASE_CYC - 1);
            end
            else
               s_d.cnt = s_q.cnt - 1'b1;
         end
         ERS_PROT:
         begin
            if (s_q.cnt == '0)
            begin
               s_d.phase = ERS_IDLE;
               s_d.done = 1'b1;
               s_d.prot_clr = 1'b1;
            end
            else
               s_d.cnt = s_q.cnt - 1'b1;
         end
         ERS_FAIL: s_d.phase = ERS_FAIL;
         default: s_d.phase = ERS_IDLE;
      endcase
   end

   always_ff @(posedge clock or negedge rst_n)
   begin
      if (!rst_n)
         s_q <= '{phase: ERS_IDLE, cnt: '0, done: 1'b0, prot_clr: 1'b0};
      else if (ce)
         s_q <= s_d;
   end

   assign busy = (s_q.phase == ERS_ARRAY) || (s_q.phase == ERS_PROT);
   assign failed = (s_q.phase == ERS_FAIL);
   assign array_phase = (s_q.phase == ERS_ARRAY);
   assign prot_phase = (s_q.phase == ERS_PROT);
   assign done = s_q.done;
   assign prot_clr = s_q.prot_clr;
endmodule

/* File: hdl/fps_top.sv */
`timescale 1ns/10ps
module fps_top
   import fps_pkg::*;
#(
   // identifier words, values arbitrary
   parameter logic [31:0] ID_WORD0 = 32'h0000_0011,
   parameter logic [31:0] ID_WORD1 = 32'h0000_0022,
   parameter logic [31:0] ID_WORD2 = 32'h0000_0033,
   parameter logic [31:0] ID_WORD3 = 32'h0000_0044
)
(
   input wire logic clock, // system clock, 10 MHz
   input wire logic rst_n, // async reset, active low
   input wire logic ce, // clock enable, freezes all state when low
   input wire logic [31:0] bus_addr, // byte address
   input wire logic [31:0] bus_wdata, // write data
   input wire logic bus_wr, // write strobe
   input wire logic bus_rd, // read strobe
   output logic [31:0] bus_rdata, // read data, cycle after strobe
   input wire logic [31:0] array_rdata, // array macro word at bus_addr
   input wire logic array_fail, // array macro erase failure
   input wire logic [NBLK-1:0] protect_init, // nonvolatile protection bits
   output logic array_erase, // array erase active
   output logic protect_erase, // protection bit erase active
   output logic [31:0] protect_bit_select_addr, // seventh cycle address
   output logic irq // level interrupt
);
   typedef struct packed {
      fps_seq_t seq;
      logic id_mode;
      logic [1:0] id_sel;
      logic [NBLK-1:0] prot;
      logic prot_loaded;
      logic [31:0] sel_addr;
      logic [31:0] rdata;
      logic [IRQ_W-1:0] int_stat;
      logic [IRQ_W-1:0] int_mask;
      logic irq;
      logic array_erase;
      logic protect_erase;
   } fps_top_state_t;

   fps_top_state_t s_q;
   fps_top_state_t s_d;
   logic start;
   logic ers_busy;
   logic ers_failed;
   logic ers_array;
   logic ers_prot;
   logic ers_done;
   logic ers_prot_clr;
   logic locked;
   logic wr_flash;
   logic rd_flash;
   logic abandon;
   logic [IRQ_W-1:0] events;

   // command cycle match; bits 1:0 must be zero or the cycle is foreign
   function automatic logic cmd_hit(
      input logic [31:0] a,
      input logic [31:0] d,
      input logic [7:0] ah,
      input logic [7:0] dv
   );
      cmd_hit = (a[15:8] == ah) && (a[1:0] == 2'b00) && (d[7:0] == dv);
   endfunction

   function automatic logic in_flash(input logic [31:0] a);
      in_flash = (a[31:19] == FLASH_REGION);
   endfunction

   function automatic logic [31:0] id_word(input logic [1:0] sel);
      case (sel)
         2'd0: id_word = ID_WORD0;
         2'd1: id_word = ID_WORD1;
         2'd2: id_word = ID_WORD2;
         default: id_word = ID_WORD3;
      endcase
   endfunction

   fps_eraser u_eraser (
      .clock(clock),
      .rst_n(rst_n),
      .ce(ce),
      .start(start),
      .array_fail(array_fail),
      .busy(ers_busy),
      .failed(ers_failed),
      .array_phase(ers_array),
      .prot_phase(ers_prot),
      .done(ers_done),
      .prot_clr(ers_prot_clr)
   );

   // a failed erase locks the sequencer just like a running one
   assign locked = ers_busy | ers_failed;
   assign wr_flash = bus_wr && in_flash(bus_addr);
   assign rd_flash = bus_rd && in_flash(bus_addr);

   always_comb
   begin
      s_d = s_q;
      start = 1'b0;
      abandon = 1'b0;

      // protection state comes from the nonvolatile bits once after reset
      if (!s_q.prot_loaded)
      begin
         s_d.prot = protect_init;
         s_d.prot_loaded = 1'b1;
      end

      if (wr_flash && !locked)
      begin
         case (s_q.seq)
            SEQ_IDLE:
            begin
               if (cmd_hit(bus_addr, bus_wdata, CMD_ADDR_A, D_UNLOCK1))
                  s_d.seq = SEQ_C1;
               else if (s_q.id_mode)
                  s_d.id_sel = bus_addr[ID_SEL_HI:ID_SEL_LO];
            end
            SEQ_C1:
            begin
               if (cmd_hit(bus_addr, bus_wdata, CMD_ADDR_B, D_UNLOCK2))
                  s_d.seq = SEQ_C2;
               else
                  abandon = 1'b1;
            end
            SEQ_C2:
            begin
               if (cmd_hit(bus_addr, bus_wdata, CMD_ADDR_A, D_READ_RESET))
               begin
                  s_d.seq = SEQ_IDLE;
                  s_d.id_mode = 1'b0;
               end
               else if (cmd_hit(bus_addr, bus_wdata, CMD_ADDR_A, D_ID_QUERY))
                  s_d.seq = SEQ_ID4;
               else if (cmd_hit(bus_addr, bus_wdata, CMD_ADDR_A, D_PROT_ERASE))
                  s_d.seq = SEQ_P4;
               else
                  abandon = 1'b1;
            end
            SEQ_ID4:
            begin
               s_d.seq = SEQ_IDLE;
               s_d.id_mode = 1'b1;
               s_d.id_sel = bus_addr[ID_SEL_HI:ID_SEL_LO];
            end
            SEQ_P4:
            begin
               if (cmd_hit(bus_addr, bus_wdata, CMD_ADDR_A, D_UNLOCK1))
                  s_d.seq = SEQ_P5;
               else
                  abandon = 1'b1;
            end
            SEQ_P5:
            begin
               if (cmd_hit(bus_addr, bus_wdata, CMD_ADDR_B, D_UNLOCK2))
                  s_d.seq = SEQ_P6;
               else
                  abandon = 1'b1;
            end
            SEQ_P6:
            begin
               if (cmd_hit(bus_addr, bus_wdata, CMD_ADDR_A, D_PROT_ERASE))
                  s_d.seq = SEQ_P7;
               else
                  abandon = 1'b1;
            end
            SEQ_P7:
            begin
               if ((bus_wdata[7:0] == D_PROT_ERASE) && (bus_addr[1:0] == 2'b00))
               begin
                  s_d.seq = SEQ_IDLE;
                  s_d.sel_addr = bus_addr;
                  s_d.id_mode = 1'b0;
                  start = 1'b1;
               end
               else
                  abandon = 1'b1;
            end
            default: s_d.seq = SEQ_IDLE;
         endcase
         if (abandon)
            s_d.seq = SEQ_IDLE;
      end

      // a finished erase ends with every block unprotected and blank; a failed one keeps the protection bits
      if (ers_prot_clr)
         s_d.prot = PROT_NONE;

      s_d.array_erase = ers_array | start;
      s_d.protect_erase = ers_prot;

      // read data stands for one cycle only
      s_d.rdata = '0;
      if (bus_rd)
      begin
         if (bus_addr == STATUS_ADDR)
         begin
            s_d.rdata[PROT_LSB +: NBLK] = s_q.prot;
            // ready waits for the cleared protection bits to land
            s_d.rdata[RDY_BIT] = ~locked & ~ers_prot_clr;
         end
         else if (bus_addr == INT_STAT_ADDR)
            s_d.rdata[IRQ_W-1:0] = s_q.int_stat;
         else if (bus_addr == INT_MASK_ADDR)
            s_d.rdata[IRQ_W-1:0] = s_q.int_mask;
         else if (rd_flash && !locked)
         begin
            if (s_q.id_mode)
               s_d.rdata = id_word(s_q.id_sel);
            else
               s_d.rdata = array_rdata;
         end
      end

      // events win over a simultaneous write-one clear
      events = '0;
      events[IRQ_DONE] = ers_done;
      events[IRQ_FAIL] = ers_array & array_fail;
      events[IRQ_ABANDON] = abandon;
      if (bus_wr && (bus_addr == INT_STAT_ADDR))
         s_d.int_stat = s_q.int_stat & ~bus_wdata[IRQ_W-1:0];
      s_d.int_stat = s_d.int_stat | events;
      if (bus_wr && (bus_addr == INT_MASK_ADDR))
         s_d.int_mask = bus_wdata[IRQ_W-1:0];
      s_d.irq = |(s_d.int_stat & s_d.int_mask);
   end

   always_ff @(posedge clock or negedge rst_n)
   begin
      if (!rst_n)
      begin
         s_q <= '{
            seq: SEQ_IDLE,
            id_mode: 1'b0,
            id_sel: 2'b00,
            prot: PROT_NONE,
            prot_loaded: 1'b0,
            sel_addr: '0,
            rdata: '0,
            int_stat: IRQ_RESET,
            int_mask: IRQ_RESET,
            irq: 1'b0,
            array_erase: 1'b0,
            protect_erase: 1'b0
         };
      end
      else if (ce)
         s_q <= s_d;
   end

   assign bus_rdata = s_q.rdata;
   assign array_erase = s_q.array_erase;
   assign protect_erase = s_q.protect_erase;
   assign protect_bit_select_addr = s_q.sel_addr;
   assign irq = s_q.irq;
endmodule

/* File: shared/fps_pkg.sv */
package fps_pkg;
   localparam logic [31:0] STATUS_ADDR = 32'h4004_0520;
   localparam logic [31:0] INT_STAT_ADDR = 32'h4004_0524;
   localparam logic [31:0] INT_MASK_ADDR = 32'h4004_0528;
   // flash array occupies addresses whose bits 31:19 match this
   localparam logic [12:0] FLASH_REGION = 13'h0000;

   localparam int NBLK = 6;
   localparam int PROT_LSB = 16;
   localparam int RDY_BIT = 0;
   localparam int ID_SEL_HI = 15;
   localparam int ID_SEL_LO = 14;
   localparam logic [5:0] PROT_NONE = 6'h00;
   localparam logic RDY_RESET = 1'b1;

   localparam logic [7:0] CMD_ADDR_A = 8'h54;
   localparam logic [7:0] CMD_ADDR_B = 8'haa;
   localparam logic [7:0] D_UNLOCK1 = 8'haa;
   localparam logic [7:0] D_UNLOCK2 = 8'h55;
   localparam logic [7:0] D_READ_RESET = 8'hf0;
   localparam logic [7:0] D_ID_QUERY = 8'h90;
   localparam logic [7:0] D_PROT_ERASE = 8'h6a;

   localparam int IRQ_W = 3;
   localparam int IRQ_DONE = 0;
   localparam int IRQ_FAIL = 1;
   localparam int IRQ_ABANDON = 2;
   localparam logic [IRQ_W-1:0] IRQ_RESET = 3'h0;

   localparam int CLK_NS = 100;
   localparam int ARRAY_ERASE_NS = 200000;
   localparam int PROT_ERASE_NS = 20000;
   localparam int ARRAY_ERASE_CYC = (ARRAY_ERASE_NS / CLK_NS < 1) ? 1 : ARRAY_ERASE_NS / CLK_NS;
   localparam int PROT_ERASE_CYC = (PROT_ERASE_NS / CLK_NS < 1) ? 1 : PROT_ERASE_NS / CLK_NS;
   localparam int CNT_W = 12;

   typedef enum logic [2:0] {
      SEQ_IDLE, SEQ_C1, SEQ_C2, SEQ_ID4, SEQ_P4, SEQ_P5, SEQ_P6, SEQ_P7
   } fps_seq_t;

   typedef enum logic [1:0] {
      ERS_IDLE, ERS_ARRAY, ERS_PROT, ERS_FAIL
   } fps_ers_t;
endpackage

/* File: verif/fps_array_model.sv */
`timescale 1ns/10ps
module fps_array_model
(
   input wire logic clock, // system clock
   input wire logic [31:0] bus_addr, // byte address
   input wire logic fail_on, // bench asks for a failing erase
   input wire logic array_erase, // array phase from the block
   output logic [31:0] array_rdata, // array word
   output logic array_fail // failure report
);
   logic erased = 1'b0;
   always @(posedge clock)
   begin
      if (array_erase)
         erased <= 1'b1;
   end
   // address dependent pattern so stale data never matches; erased cells read ones
   assign array_rdata = erased ? 32'hffff_ffff : ~bus_addr;
   assign array_fail = fail_on & array_erase;
endmodule

/* File: verif/fps_monitor.sv */
`timescale 1ns/10ps
module fps_monitor
   import fps_pkg::*;
(
   input wire logic clock, // system clock
   input wire logic rst_n, // async reset
   input wire logic [31:0] bus_addr, // byte address
   input wire logic [31:0] bus_wdata, // write data
   input wire logic bus_wr, // write strobe
   input wire logic bus_rd, // read strobe
   input wire logic [31:0] bus_rdata, // read data
   input wire logic array_fail, // macro failure
   input wire logic array_erase, // array phase
   input wire logic protect_erase, // protection phase
   input wire logic [31:0] protect_bit_select_addr // seventh cycle address
);
   default clocking cb @(posedge clock); endclocking
   default disable iff (!rst_n);
   sequence s_stat_rd;
      bus_rd && bus_addr == STATUS_ADDR;
   endsequence
   sequence s_start;
      $rose(array_erase);
   endsequence
   property p_rd_idle;
      !$past(bus_rd) |-> bus_rdata == 32'h0;
   endproperty
   a_rd_idle: assert property (p_rd_idle) else $error("read data outside answer cycle");
   property p_rsvd;
      s_stat_rd |=> bus_rdata[31:22] == 10'h0 && bus_rdata[15:1] == 15'h0;
   endproperty
   a_rsvd: assert property (p_rsvd) else $error("status reserved bit set");
   property p_busy;
      s_stat_rd ##0 array_erase |=> bus_rdata[0] == 1'b0;
   endproperty
   a_busy: assert property (p_busy) else $error("ready while erasing");
   property p_start;
      s_start |-> $past(bus_wr) && $past(bus_wdata[7:0]) == D_PROT_ERASE;
   endproperty
   a_start: assert property (p_start) else $error("erase without seventh write");
   property p_sel;
      s_start |-> protect_bit_select_addr == $past(bus_addr);
   endproperty
   a_sel: assert property (p_sel) else $error("wrong protection address");
   property p_hold;
      s_start ##0 !array_fail |-> array_erase[*8];
   endproperty
   a_hold: assert property (p_hold) else $error("array phase too short");
   property p_order;
      $fell(array_erase) && !$past(array_fail) |-> ##[0:2] protect_erase;
   endproperty
   a_order: assert property (p_order) else $error("no protection phase");
   property p_after;
      $rose(protect_erase) |-> $past(array_erase) || $past(array_erase, 2);
   endproperty
   a_after: assert property (p_after) else $error("protection before array");
endmodule

/* File: verif/tb.sv */
`timescale 1ns/10ps
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin fail_count++; \
   $display("ERROR %0t mismatch %h %h", $time, a, b); end end
module tb;
   import fps_pkg::*;
   logic clock = 0, rst_n = 0, ce = 1, bus_wr = 0, bus_rd = 0, fail_on = 0;
   logic [31:0] bus_addr = 0, bus_wdata = 0, bus_rdata, array_rdata, psel, v;
   logic array_fail, array_erase, protect_erase, irq;
   logic [5:0] protect_init = 6'h3f;
   int fail_count = 0, check_count = 0, cyc = 0, i;
   fps_top #(.ID_WORD0(32'h10), .ID_WORD1(32'h21), .ID_WORD2(32'h32), .ID_WORD3(32'h43))
   dut (.clock(clock), .rst_n(rst_n), .ce(ce), .bus_addr(bus_addr), .bus_wdata(bus_wdata),
      .bus_wr(bus_wr), .bus_rd(bus_rd), .bus_rdata(bus_rdata), .array_rdata(array_rdata),
      .array_fail(array_fail), .protect_init(protect_init), .array_erase(array_erase),
      .protect_erase(protect_erase), .protect_bit_select_addr(psel), .irq(irq));
   fps_array_model u_arr (.clock(clock), .bus_addr(bus_addr), .fail_on(fail_on),
      .array_erase(array_erase), .array_rdata(array_rdata), .array_fail(array_fail));
   initial forever #50 clock = ~clock;
   task finish_test;
      if (fail_count == 0 && check_count > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask
   always @(posedge clock)
   begin
      cyc++;
      if (cyc > 30000)
      begin
         fail_count++;
         finish_test;
      end
   end
   // word aligned single 32-bit cycles only
   task acc(input logic w, input logic [31:0] a, input logic [31:0] d);
      @(posedge clock);
      bus_wr <= w;
      bus_rd <= !w;
      bus_addr <= a;
      bus_wdata <= d;
      @(posedge clock);
      bus_wr <= 0;
      bus_rd <= 0;
      @(negedge clock);
      v = bus_rdata;
   endtask
   task rdc(input logic [31:0] a, input logic [31:0] e);
      acc(0, a, 0);
      `CHK(v, e)
   endtask
   task cmd(input logic [7:0] d);
      acc(1, 32'h5400, 32'haa);
      acc(1, 32'haa00, 32'h55);
      acc(1, 32'h5400, {24'h0, d});
   endtask
   task pe(input logic [31:0] a);
      cmd(D_PROT_ERASE);
      cmd(D_PROT_ERASE);
      acc(1, a, 32'h6a);
   endtask
   task wrdy;
      v = 0;
      for (int k = 0; k < 1500 && v[0] !== 1'b1; k++)
         acc(0, STATUS_ADDR, 0);
   endtask
   task rst(input logic [5:0] p);
      rst_n <= 0;
      protect_init <= p;
      repeat (2) @(posedge clock);
      rst_n <= 1;
      repeat (2) @(posedge clock);
   endtask
   initial
   begin
      rst(6'h3f);
      rdc(STATUS_ADDR, 32'h003f_0001);
      acc(1, STATUS_ADDR, 0);
      rdc(STATUS_ADDR, 32'h003f_0001);
      rdc(32'h4004_0600, 0);
      acc(1, INT_MASK_ADDR, 32'h1);
      rdc(INT_MASK_ADDR, 32'h1);
      cmd(D_ID_QUERY);
      for (i = 0; i < 4; i++)
      begin
         acc(1, i << 14, 0);
         rdc(32'h100, 32'h10 + i * 32'h11);
      end
      cmd(D_READ_RESET);
      rdc(32'h100, ~32'h100);
      acc(1, 32'h5400, 32'haa);
      acc(1, 32'h5400, 32'h55);
      rdc(INT_STAT_ADDR, 32'h4);
      `CHK(irq, 1'b0)
      acc(1, INT_STAT_ADDR, 32'h7);
      pe(32'h4000);
      rdc(STATUS_ADDR, 32'h003f_0000);
      cmd(D_ID_QUERY);
      acc(1, 32'h4000, 0);
      rdc(32'h100, 0);
      wrdy;
      rdc(STATUS_ADDR, 32'h1);
      rdc(32'h100, 32'hffff_ffff);
      `CHK(psel, 32'h4000)
      `CHK(irq, 1'b1)
      acc(1, INT_STAT_ADDR, 32'h7);
      repeat (2) @(negedge clock);
      `CHK(irq, 1'b0)
      rst(6'h05);
      pe(32'h8000);
      repeat (100) @(posedge clock);
      rst(6'h05);
      rdc(STATUS_ADDR, 32'h0005_0001);
      pe(32'h8000);
      wrdy;
      rdc(STATUS_ADDR, 32'h1);
      fail_on <= 1;
      pe(32'h0);
      repeat (2500) @(posedge clock);
      acc(0, STATUS_ADDR, 0);
      `CHK(v[0], 1'b0)
      acc(0, INT_STAT_ADDR, 0);
      `CHK(v[1], 1'b1)
      fail_on <= 0;
      rst(6'h3f);
      rdc(STATUS_ADDR, 32'h003f_0001);
      finish_test;
   end
endmodule
bind fps_top fps_monitor u_mon (.clock(clock), .rst_n(rst_n), .bus_addr(bus_addr),
   .bus_wdata(bus_wdata), .bus_wr(bus_wr), .bus_rd(bus_rd), .bus_rdata(bus_rdata),
   .array_fail(array_fail), .array_erase(array_erase), .protect_erase(protect_erase),
   .protect_bit_select_addr(protect_bit_select_addr));
